// [core/rx_ctrl_pkg.sv]
package rx_ctrl_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int BYTE_W     = 8;
	localparam int ADDR_W     = 7;
	localparam int IRQ_W      = 16;
	localparam int SUBCODE_N  = 10;
	localparam int CU_BUF_N   = 24;

	// ****************************************
	// register pointer layout
	// ****************************************
	localparam int PTR_AUTO_ADVANCE_ENABLE_BIT = 7;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [6:0] ADDR_STEP = 7'h01;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [6:0] ADDR_CONTROL_ONE      = 7'h01;
	localparam logic [6:0] ADDR_CONTROL_TWO      = 7'h02;
	localparam logic [6:0] ADDR_CLOCK_SOURCE     = 7'h04;
	localparam logic [6:0] ADDR_SERIAL_FORMAT    = 7'h06;
	localparam logic [6:0] ADDR_IRQ_STATUS_ONE   = 7'h07;
	localparam logic [6:0] ADDR_IRQ_STATUS_TWO   = 7'h08;
	localparam logic [6:0] ADDR_IRQ_MASK_ONE     = 7'h09;
	localparam logic [6:0] ADDR_IRQ_MODE_ONE_HI  = 7'h0A;
	localparam logic [6:0] ADDR_IRQ_MODE_ONE_LO  = 7'h0B;
	localparam logic [6:0] ADDR_IRQ_MASK_TWO     = 7'h0C;
	localparam logic [6:0] ADDR_IRQ_MODE_TWO_HI  = 7'h0D;
	localparam logic [6:0] ADDR_IRQ_MODE_TWO_LO  = 7'h0E;
	localparam logic [6:0] ADDR_RX_CHAN_STATUS   = 7'h0F;
	localparam logic [6:0] ADDR_RX_ERRORS        = 7'h10;
	localparam logic [6:0] ADDR_RX_ERROR_MASK    = 7'h11;
	localparam logic [6:0] ADDR_STATUS_BUF_CTRL  = 7'h12;
	localparam logic [6:0] ADDR_USER_BUF_CTRL    = 7'h13;
	localparam logic [6:0] ADDR_SUBCODE_FIRST    = 7'h14;
	localparam logic [6:0] ADDR_SUBCODE_LAST     = 7'h1D;
	localparam logic [6:0] ADDR_CLOCK_RATIO      = 7'h1E;
	localparam logic [6:0] ADDR_CU_BUF_FIRST     = 7'h20;
	localparam logic [6:0] ADDR_CU_BUF_LAST      = 7'h37;
	localparam logic [6:0] ADDR_IDENTITY         = 7'h7F;

	// ****************************************
	// write masks
	// ****************************************
	localparam logic [7:0] WMASK_CONTROL_ONE  = 8'hA6;
	localparam logic [7:0] WMASK_CONTROL_TWO  = 8'h7F;
	localparam logic [7:0] WMASK_CLOCK_SOURCE = 8'h42;
	localparam logic [7:0] FIXED_CLOCK_SOURCE = 8'h01;
	localparam logic [7:0] WMASK_SERIAL_FMT   = 8'hFF;
	localparam logic [7:0] WMASK_IRQ_ONE      = 8'h45;
	localparam logic [7:0] WMASK_IRQ_TWO      = 8'h0A;
	localparam logic [7:0] WMASK_ERROR_MASK   = 8'h7F;
	localparam logic [7:0] WMASK_STATUS_BUF   = 8'h3B;
	localparam logic [7:0] WMASK_USER_BUF     = 8'h02;
	localparam logic [7:0] REG_RESET          = 8'h00;
	localparam logic [7:0] READ_ZERO          = 8'h00;

	// identity value is arbitrary
	localparam logic [7:0] IDENTITY_VALUE     = 8'h5A;

	// ****************************************
	// field positions
	// ****************************************
	localparam int C1_SWITCH_BIT   = 7;
	localparam int C1_MUTE_BIT     = 5;
	localparam int C1_POL_LSB      = 1;
	localparam int C2_HOLD_LSB     = 5;
	localparam int C2_RATIO_BIT    = 4;
	localparam int C2_MONO_BIT     = 3;
	localparam int C2_SEL_LSB      = 0;
	localparam int CS_RUN_BIT      = 6;
	localparam int CS_SOURCE_BIT   = 1;

	localparam logic [2:0] INPUT_SEL_RESERVED = 3'h7;

	// ****************************************
	// irq modes and pin polarity
	// ****************************************
	localparam logic [1:0] MODE_RISE  = 2'h0;
	localparam logic [1:0] MODE_FALL  = 2'h1;
	localparam logic [1:0] MODE_LEVEL = 2'h2;

	localparam logic [1:0] POL_ACTIVE_HIGH = 2'h0;
	localparam logic [1:0] POL_ACTIVE_LOW  = 2'h1;
	localparam logic [1:0] POL_OPEN_DRAIN  = 2'h2;

	typedef enum logic [0:0] {ST_STOPPED, ST_RUNNING} run_state_t;

endpackage

// [core/irq_source_cell.sv]
`timescale 1ns/1ps

module irq_source_cell
	import rx_ctrl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic       src,
	input  wire logic       mask,
	input  wire logic [1:0] mode,
	input  wire logic       rd_clear,
	output logic            status
);

	logic prev_reg;
	logic prev_next;
	logic status_reg;
	logic status_next;
	logic event_hit;

	// ****************************************
	// event detect and sticky bit
	// ****************************************
	// set wins over a read clear in the same cycle
	always_comb begin
		case (mode)
			MODE_RISE:  event_hit = src & ~prev_reg;  // R15
			MODE_FALL:  event_hit = ~src & prev_reg;  // R15
			MODE_LEVEL: event_hit = src;              // R15
			default:    event_hit = 1'b0;
		endcase
		prev_next   = run ? src : 1'b0;
		status_next = status_reg;
		if (rd_clear) begin
			status_next = (mode == MODE_LEVEL) & src;  // R13
		end
		if (event_hit) begin
			status_next = 1'b1;  // R13
		end
		status_next = status_next & mask & run;  // R14 R4
	end

	// registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_reg   <= 1'b0;
			status_reg <= 1'b0;
		end else begin
			prev_reg   <= prev_next;
			status_reg <= status_next;
		end
	end

	assign status = status_reg;

endmodule

// [core/audio_receiver_control_regs.sv]
// Function
// R1: pointer bit 7 enables auto-advance, reset 0; pointer steps after each data byte
// R2: low seven pointer bits address the register the next data byte uses
// R3: host must not write reserved addresses; device ignores such writes
// R4: run bit 0 stops internal clocks and holds internal state machines reset
// R5: register port keeps reading and writing while run bit is 0
// R6: while stopped, channel-status and user buffer accesses have no effect
// R7: run bit resets to 0; device idles until host sets it
// R8: host should set run only after input clocks are stable
// R9: recovered-clock source 0 selects PLL clock at 256 times sample rate
// R10: recovered-clock source 1 bypasses PLL, external clock on recovered-clock pin
// R11: mono bit 0 stereo; 1 treats subframes as consecutive mono samples
// R12: three-bit selector picks input 0 to 6, default 0, code 7 reserved
// R13: status bits stick until read; read clears unless level source still true
// R14: mask 1 passes source to status and irq; mask 0 blocks, reads zero
// R15: two-bit mode per source: rising, falling, level, reserved
// R16: clock-switch set drives system clock onto recovered pin when PLL unlocks; code switches only while running
// R17: irq output active high, active low, or open-drain low; default high
`timescale 1ns/1ps

module audio_receiver_control_regs
	import rx_ctrl_pkg::*;
(
	input  wire logic                              CORE_CLK,
	input  wire logic                              RST,
	input  wire logic                              PTR_WR,
	input  wire logic                              DATA_WR,
	input  wire logic                              DATA_RD,
	input  wire logic [rx_ctrl_pkg::BYTE_W-1:0]    WR_DATA,
	input  wire logic [rx_ctrl_pkg::IRQ_W-1:0]     IRQ_SOURCES,
	input  wire logic                              PLL_LOCKED,
	input  wire logic [rx_ctrl_pkg::BYTE_W-1:0]    RX_CS_DATA,
	input  wire logic [rx_ctrl_pkg::BYTE_W-1:0]    RX_ERRORS,
	input  wire logic [rx_ctrl_pkg::SUBCODE_N*8-1:0] SUBCODE_BYTES,
	input  wire logic [rx_ctrl_pkg::BYTE_W-1:0]    CLOCK_RATIO_IN,
	input  wire logic [rx_ctrl_pkg::CU_BUF_N*8-1:0] CU_BUFFER_BYTES,
	output logic      [rx_ctrl_pkg::BYTE_W-1:0]    RD_DATA,
	output logic      [rx_ctrl_pkg::BYTE_W-1:0]    POINTER,
	output logic                                   CORE_CLK_EN,
	output logic                                   CORE_RESET,
	output logic                                   PLL_BYPASS,
	output logic                                   RECOVERED_CLOCK_OUTPUT_SWITCH,
	output logic                                   MONO_MODE,
	output logic      [2:0]                        INPUT_SELECT,
	output logic                                   INPUT_SELECT_VALID,
	output logic                                   SERIAL_MUTE,
	output logic      [1:0]                        SAMPLE_HOLD,
	output logic                                   RECOVERED_CLOCK_OUTPUT_HALF_RATE,
	output logic      [rx_ctrl_pkg::BYTE_W-1:0]    SERIAL_FORMAT,
	output logic      [rx_ctrl_pkg::BYTE_W-1:0]    STATUS_BUF_CTRL,
	output logic      [rx_ctrl_pkg::BYTE_W-1:0]    USER_BUF_CTRL,
	output logic      [rx_ctrl_pkg::BYTE_W-1:0]    ERROR_MASK,
	output logic                                   CU_BUF_READ,
	output logic                                   IRQ_OUT,
	output logic                                   IRQ_OE
);

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0]  ptr_reg, ptr_next;
	logic [7:0]  ctrl1_reg, ctrl1_next;
	logic [7:0]  ctrl2_reg, ctrl2_next;
	logic [7:0]  clksrc_reg, clksrc_next;
	logic [7:0]  fmt_reg, fmt_next;
	logic [7:0]  mask1_reg, mask1_next;
	logic [7:0]  mask2_reg, mask2_next;
	logic [7:0]  mhi1_reg, mhi1_next;
	logic [7:0]  mlo1_reg, mlo1_next;
	logic [7:0]  mhi2_reg, mhi2_next;
	logic [7:0]  mlo2_reg, mlo2_next;
	logic [7:0]  errmask_reg, errmask_next;
	logic [7:0]  sbuf_reg, sbuf_next;
	logic [7:0]  ubuf_reg, ubuf_next;
	logic [7:0]  rd_reg, rd_next;
	logic        cu_rd_reg, cu_rd_next;
	logic        irq_reg, irq_next;
	logic        irq_oe_reg, irq_oe_next;
	logic        swclk_reg, swclk_next;
	logic        sel_valid_reg, sel_valid_next;
	logic [2:0]  lock_sync_reg;
	logic        lock_reg, lock_next;
	run_state_t  state_reg, state_next;
	logic [6:0]  addr;
	logic        access;
	logic        run;
	logic [15:0] irq_status;
	logic [15:0] irq_mask;
	logic [15:0] mode_hi;
	logic [15:0] mode_lo;
	logic [15:0] rd_clear;
	logic [7:0]  read_value;
	logic        any_irq;
	logic [6:0]  sub_idx;
	logic [6:0]  cu_idx;

	assign addr     = ptr_reg[ADDR_W-1:0];  // R2
	assign access   = DATA_WR | DATA_RD;
	assign run      = clksrc_reg[CS_RUN_BIT];
	assign irq_mask = {mask2_reg, mask1_reg};
	assign mode_hi  = {mhi2_reg, mhi1_reg};
	assign mode_lo  = {mlo2_reg, mlo1_reg};
	assign sub_idx  = addr - ADDR_SUBCODE_FIRST;
	assign cu_idx   = addr - ADDR_CU_BUF_FIRST;

	// ****************************************
	// interrupt sources
	// ****************************************
	// one cell per status bit; a status read clears its byte
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W; gi = gi + 1) begin : g_irq
			assign rd_clear[gi] = DATA_RD & ~PTR_WR &
				(addr == ((gi < BYTE_W) ? ADDR_IRQ_STATUS_ONE : ADDR_IRQ_STATUS_TWO));
			irq_source_cell u_cell (
				.clk      (CORE_CLK),
				.rst      (RST),
				.run      (state_reg == ST_RUNNING),
				.src      (IRQ_SOURCES[gi]),
				.mask     (irq_mask[gi]),
				.mode     ({mode_hi[gi], mode_lo[gi]}),
				.rd_clear (rd_clear[gi]),
				.status   (irq_status[gi])
			);
		end
	endgenerate

	// ****************************************
	// read data selection
	// ****************************************
	always_comb begin
		read_value = READ_ZERO;
		case (addr)
			ADDR_CONTROL_ONE:     read_value = ctrl1_reg;
			ADDR_CONTROL_TWO:     read_value = ctrl2_reg;
			ADDR_CLOCK_SOURCE:    read_value = clksrc_reg | FIXED_CLOCK_SOURCE;
			ADDR_SERIAL_FORMAT:   read_value = fmt_reg;
			ADDR_IRQ_STATUS_ONE:  read_value = irq_status[7:0];   // R14
			ADDR_IRQ_STATUS_TWO:  read_value = irq_status[15:8];  // R14
			ADDR_IRQ_MASK_ONE:    read_value = mask1_reg;
			ADDR_IRQ_MODE_ONE_HI: read_value = mhi1_reg;
			ADDR_IRQ_MODE_ONE_LO: read_value = mlo1_reg;
			ADDR_IRQ_MASK_TWO:    read_value = mask2_reg;
			ADDR_IRQ_MODE_TWO_HI: read_value = mhi2_reg;
			ADDR_IRQ_MODE_TWO_LO: read_value = mlo2_reg;
			ADDR_RX_CHAN_STATUS:  read_value = RX_CS_DATA;
			ADDR_RX_ERRORS:       read_value = RX_ERRORS;
			ADDR_RX_ERROR_MASK:   read_value = errmask_reg;
			ADDR_STATUS_BUF_CTRL: read_value = sbuf_reg;
			ADDR_USER_BUF_CTRL:   read_value = ubuf_reg;
			ADDR_CLOCK_RATIO:     read_value = CLOCK_RATIO_IN;
			ADDR_IDENTITY:        read_value = IDENTITY_VALUE;
			default: begin
				if (addr >= ADDR_SUBCODE_FIRST && addr <= ADDR_SUBCODE_LAST) begin
					read_value = SUBCODE_BYTES[sub_idx*8 +: 8];
				end else if (addr >= ADDR_CU_BUF_FIRST && addr <= ADDR_CU_BUF_LAST &&
						state_reg == ST_RUNNING) begin
					read_value = CU_BUFFER_BYTES[cu_idx*8 +: 8];  // R6
				end
			end
		endcase
	end

	// ****************************************
	// pointer and register file next values
	// ****************************************
	// register port runs whatever the run bit
	always_comb begin
		ptr_next     = ptr_reg;
		ctrl1_next   = ctrl1_reg;
		ctrl2_next   = ctrl2_reg;
		clksrc_next  = clksrc_reg;
		fmt_next     = fmt_reg;
		mask1_next   = mask1_reg;
		mask2_next   = mask2_reg;
		mhi1_next    = mhi1_reg;
		mlo1_next    = mlo1_reg;
		mhi2_next    = mhi2_reg;
		mlo2_next    = mlo2_reg;
		errmask_next = errmask_reg;
		sbuf_next    = sbuf_reg;
		ubuf_next    = ubuf_reg;
		rd_next      = rd_reg;
		cu_rd_next   = 1'b0;
		if (PTR_WR) begin
			ptr_next = WR_DATA;  // R1 R2
		end else if (access) begin
			if (DATA_WR) begin  // R5
				case (addr)  // R3
					ADDR_CONTROL_ONE:     ctrl1_next   = WR_DATA & WMASK_CONTROL_ONE;
					ADDR_CONTROL_TWO:     ctrl2_next   = WR_DATA & WMASK_CONTROL_TWO;
					ADDR_CLOCK_SOURCE:    clksrc_next  = WR_DATA & WMASK_CLOCK_SOURCE;  // R7
					ADDR_SERIAL_FORMAT:   fmt_next     = WR_DATA & WMASK_SERIAL_FMT;
					ADDR_IRQ_MASK_ONE:    mask1_next   = WR_DATA & WMASK_IRQ_ONE;
					ADDR_IRQ_MODE_ONE_HI: mhi1_next    = WR_DATA & WMASK_IRQ_ONE;
					ADDR_IRQ_MODE_ONE_LO: mlo1_next    = WR_DATA & WMASK_IRQ_ONE;
					ADDR_IRQ_MASK_TWO:    mask2_next   = WR_DATA & WMASK_IRQ_TWO;
					ADDR_IRQ_MODE_TWO_HI: mhi2_next    = WR_DATA & WMASK_IRQ_TWO;
					ADDR_IRQ_MODE_TWO_LO: mlo2_next    = WR_DATA & WMASK_IRQ_TWO;
					ADDR_RX_ERROR_MASK:   errmask_next = WR_DATA & WMASK_ERROR_MASK;
					ADDR_STATUS_BUF_CTRL: sbuf_next    = WR_DATA & WMASK_STATUS_BUF;
					ADDR_USER_BUF_CTRL:   ubuf_next    = WR_DATA & WMASK_USER_BUF;
					default:              ;
				endcase
			end else begin
				rd_next    = read_value;
				cu_rd_next = (addr >= ADDR_CU_BUF_FIRST) && (addr <= ADDR_CU_BUF_LAST) &&
					(state_reg == ST_RUNNING);  // R6
			end
			if (ptr_reg[PTR_AUTO_ADVANCE_ENABLE_BIT]) begin
				ptr_next = {ptr_reg[PTR_AUTO_ADVANCE_ENABLE_BIT], addr + ADDR_STEP};  // R1
			end
		end
	end

	// registers
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ptr_reg     <= PTR_RESET;
			ctrl1_reg   <= REG_RESET;
			ctrl2_reg   <= REG_RESET;
			clksrc_reg  <= REG_RESET;  // R7
			fmt_reg     <= REG_RESET;
			mask1_reg   <= REG_RESET;
			mask2_reg   <= REG_RESET;
			mhi1_reg    <= REG_RESET;
			mlo1_reg    <= REG_RESET;
			mhi2_reg    <= REG_RESET;
			mlo2_reg    <= REG_RESET;
			errmask_reg <= REG_RESET;
			sbuf_reg    <= REG_RESET;
			ubuf_reg    <= REG_RESET;
			rd_reg      <= REG_RESET;
			cu_rd_reg   <= 1'b0;
		end else begin
			ptr_reg     <= ptr_next;
			ctrl1_reg   <= ctrl1_next;
			ctrl2_reg   <= ctrl2_next;
			clksrc_reg  <= clksrc_next;
			fmt_reg     <= fmt_next;
			mask1_reg   <= mask1_next;
			mask2_reg   <= mask2_next;
			mhi1_reg    <= mhi1_next;
			mlo1_reg    <= mlo1_next;
			mhi2_reg    <= mhi2_next;
			mlo2_reg    <= mlo2_next;
			errmask_reg <= errmask_next;
			sbuf_reg    <= sbuf_next;
			ubuf_reg    <= ubuf_next;
			rd_reg      <= rd_next;
			cu_rd_reg   <= cu_rd_next;
		end
	end

	// ****************************************
	// run state, lock, clock switch, irq pin
	// ****************************************
	// lock changes count only when second and third stages agree
	always_comb begin
		state_next     = run ? ST_RUNNING : ST_STOPPED;  // R4 R7
		lock_next      = (lock_sync_reg[1] == lock_sync_reg[2]) ? lock_sync_reg[2] : lock_reg;
		swclk_next     = ctrl1_reg[C1_SWITCH_BIT] & ~lock_reg & (state_reg == ST_RUNNING);  // R16
		sel_valid_next = ctrl2_reg[C2_SEL_LSB +: 3] != INPUT_SEL_RESERVED;  // R12
		any_irq        = |irq_status;
		case (ctrl1_reg[C1_POL_LSB +: 2])  // R17
			POL_ACTIVE_LOW: begin
				irq_next    = ~any_irq;
				irq_oe_next = 1'b1;
			end
			POL_OPEN_DRAIN: begin
				irq_next    = 1'b0;
				irq_oe_next = any_irq;
			end
			default: begin
				irq_next    = any_irq;
				irq_oe_next = 1'b1;
			end
		endcase
	end

	// registers
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state_reg     <= ST_STOPPED;
			lock_sync_reg <= 3'h0;
			lock_reg      <= 1'b0;
			swclk_reg     <= 1'b0;
			sel_valid_reg <= 1'b1;
			irq_reg       <= 1'b0;
			irq_oe_reg    <= 1'b1;
		end else begin
			state_reg     <= state_next;
			lock_sync_reg <= {lock_sync_reg[1:0], PLL_LOCKED};
			lock_reg      <= lock_next;
			swclk_reg     <= swclk_next;
			sel_valid_reg <= sel_valid_next;
			irq_reg       <= irq_next;
			irq_oe_reg    <= irq_oe_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign RD_DATA            = rd_reg;
	assign POINTER            = ptr_reg;
	assign CORE_CLK_EN        = state_reg == ST_RUNNING;  // R4
	assign CORE_RESET         = state_reg == ST_STOPPED;  // R4
	assign PLL_BYPASS         = clksrc_reg[CS_SOURCE_BIT];  // R9 R10
	assign RECOVERED_CLOCK_OUTPUT_SWITCH        = swclk_reg;
	assign MONO_MODE          = ctrl2_reg[C2_MONO_BIT];  // R11
	assign INPUT_SELECT       = ctrl2_reg[C2_SEL_LSB +: 3];  // R12
	assign INPUT_SELECT_VALID = sel_valid_reg;
	assign SERIAL_MUTE        = ctrl1_reg[C1_MUTE_BIT];
	assign SAMPLE_HOLD        = ctrl2_reg[C2_HOLD_LSB +: 2];
	assign RECOVERED_CLOCK_OUTPUT_HALF_RATE     = ctrl2_reg[C2_RATIO_BIT];
	assign SERIAL_FORMAT      = fmt_reg;
	assign STATUS_BUF_CTRL    = sbuf_reg;
	assign USER_BUF_CTRL      = ubuf_reg;
	assign ERROR_MASK         = errmask_reg;
	assign CU_BUF_READ        = cu_rd_reg;
	assign IRQ_OUT            = irq_reg;
	assign IRQ_OE             = irq_oe_reg;

endmodule

// [sim/audio_receiver_control_regs_properties.sv]
`timescale 1ns/1ps

module audio_receiver_control_regs_properties
	import rx_ctrl_pkg::*;
(
	input wire logic       CORE_CLK,
	input wire logic       RST,
	input wire logic       PTR_WR,
	input wire logic       DATA_WR,
	input wire logic       DATA_RD,
	input wire logic [7:0] WR_DATA,
	input wire logic       PLL_LOCKED,
	input wire logic [7:0] RD_DATA,
	input wire logic [7:0] POINTER,
	input wire logic       CORE_CLK_EN,
	input wire logic       CORE_RESET,
	input wire logic       PLL_BYPASS,
	input wire logic       RECOVERED_CLOCK_OUTPUT_SWITCH,
	input wire logic       MONO_MODE,
	input wire logic [2:0] INPUT_SELECT,
	input wire logic       CU_BUF_READ
);
	// ********
	// request decode
	// ********
	logic wr;
	logic rd;
	logic dat;
	logic in_buf;

	// pointer load wins, then write, then read
	assign wr     = DATA_WR && !PTR_WR;
	assign rd     = DATA_RD && !DATA_WR && !PTR_WR;
	assign dat    = (DATA_WR || DATA_RD) && !PTR_WR;
	assign in_buf = POINTER[6:0] >= ADDR_CU_BUF_FIRST && POINTER[6:0] <= ADDR_CU_BUF_LAST;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	// ********
	// properties
	// ********
	a_ptr_load: assert property (PTR_WR |=> POINTER == $past(WR_DATA))
		else $error("no pointer load");
	a_ptr_advance: assert property (dat && POINTER[7] |=>
		POINTER[6:0] == $past(POINTER[6:0]) + ADDR_STEP) else $error("no pointer step");
	a_ptr_hold: assert property (dat && !POINTER[7] |=> $stable(POINTER))
		else $error("pointer moved");
	a_ident_read: assert property (rd && POINTER[6:0] == ADDR_IDENTITY |=>
		RD_DATA == IDENTITY_VALUE) else $error("identity read wrong");
	a_run_stop: assert property (wr && POINTER[6:0] == ADDR_CLOCK_SOURCE &&
		!WR_DATA[CS_RUN_BIT] |-> ##2 CORE_RESET && !CORE_CLK_EN) else $error("core not stopped");
	a_run_start: assert property (wr && POINTER[6:0] == ADDR_CLOCK_SOURCE &&
		WR_DATA[CS_RUN_BIT] |-> ##[1:2] CORE_CLK_EN) else $error("no core start");
	a_buf_blocked: assert property (rd && in_buf && CORE_RESET && $past(CORE_RESET) |=>
		!CU_BUF_READ && RD_DATA == READ_ZERO) else $error("buffer read while stopped");
	a_buf_pulse: assert property (CU_BUF_READ |->
		$past(rd) && $past(in_buf) && !$past(CORE_RESET)) else $error("stray buffer strobe");
	a_bypass_set: assert property (wr && POINTER[6:0] == ADDR_CLOCK_SOURCE |=>
		PLL_BYPASS == $past(WR_DATA[CS_SOURCE_BIT])) else $error("clock source not applied");
	a_ctrl_two_set: assert property (wr && POINTER[6:0] == ADDR_CONTROL_TWO |=>
		MONO_MODE == $past(WR_DATA[C2_MONO_BIT]) && INPUT_SELECT == $past(WR_DATA[2:0]))
		else $error("control two not applied");
	a_lock_switch: assert property (PLL_LOCKED [*6] |-> !RECOVERED_CLOCK_OUTPUT_SWITCH)
		else $error("clock switch while locked");

	c_buf_read: cover property (rd && in_buf && !CORE_RESET);
	c_burst: cover property (dat && POINTER[7] ##1 dat);
	c_switch: cover property ($rose(RECOVERED_CLOCK_OUTPUT_SWITCH));
endmodule

bind audio_receiver_control_regs audio_receiver_control_regs_properties i_props (.*);

// [sim/host_port_model.sv]
`timescale 1ns/1ps

module host_port_model
	import rx_ctrl_pkg::*;
(
	input  wire logic       CORE_CLK,
	input  wire logic [7:0] RD_DATA,
	output logic            PTR_WR,
	output logic            DATA_WR,
	output logic            DATA_RD,
	output logic [7:0]      WR_DATA
);
	int         idle;       // idle cycles first
	logic [7:0] rbuf [0:7]; // bytes read last

	// quiet port at start
	initial begin
		idle = 0;
		PTR_WR = 1'b0;
		DATA_WR = 1'b0;
		DATA_RD = 1'b0;
		WR_DATA = 8'h00;
	end

	// n back-to-back bytes; no writes to reserved places
	task automatic xfer(input logic p, input logic w, input logic [7:0] d, input int n);
		repeat (idle + 1) @(posedge CORE_CLK);
		#1;
		PTR_WR = p;
		DATA_WR = w;
		DATA_RD = !p && !w;
		WR_DATA = d;
		for (int i = 0; i < n; i++) begin
			@(posedge CORE_CLK);
			#1;
			rbuf[i] = RD_DATA;
		end
		PTR_WR = 1'b0;
		DATA_WR = 1'b0;
		DATA_RD = 1'b0;
		WR_DATA = ~d; // no stale value
	endtask
endmodule

// [sim/audio_receiver_control_regs_tb_top.sv]
`timescale 1ns/1ps

module audio_receiver_control_regs_tb_top;
	import rx_ctrl_pkg::*;

	logic         CORE_CLK, RST, PTR_WR, DATA_WR, DATA_RD, PLL_LOCKED;
	logic [7:0]   WR_DATA, RD_DATA, POINTER, RX_CS_DATA, RX_ERRORS, CLOCK_RATIO_IN;
	logic [15:0]  IRQ_SOURCES;
	logic [79:0]  SUBCODE_BYTES;
	logic [191:0] CU_BUFFER_BYTES;
	logic         CORE_CLK_EN, CORE_RESET, PLL_BYPASS, RECOVERED_CLOCK_OUTPUT_SWITCH, MONO_MODE;
	logic [2:0]   INPUT_SELECT;
	logic         INPUT_SELECT_VALID, CU_BUF_READ, IRQ_OUT, IRQ_OE;
	int           errors, tests_run;

	audio_receiver_control_regs i_audio_receiver_control_regs (.CORE_CLK, .RST, .PTR_WR,
		.DATA_WR, .DATA_RD, .WR_DATA, .IRQ_SOURCES, .PLL_LOCKED, .RX_CS_DATA, .RX_ERRORS,
		.SUBCODE_BYTES, .CLOCK_RATIO_IN, .CU_BUFFER_BYTES, .RD_DATA, .POINTER, .CORE_CLK_EN,
		.CORE_RESET, .PLL_BYPASS, .RECOVERED_CLOCK_OUTPUT_SWITCH, .MONO_MODE, .INPUT_SELECT, .INPUT_SELECT_VALID,
		.SERIAL_MUTE(), .SAMPLE_HOLD(), .RECOVERED_CLOCK_OUTPUT_HALF_RATE(), .SERIAL_FORMAT(), .STATUS_BUF_CTRL(),
		.USER_BUF_CTRL(), .ERROR_MASK(), .CU_BUF_READ, .IRQ_OUT, .IRQ_OE);

	host_port_model i_host_port_model (.CORE_CLK, .RD_DATA, .PTR_WR, .DATA_WR, .DATA_RD, .WR_DATA);

	// ********
	// helpers
	// ********
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic xf(input logic p, input logic w, input logic [7:0] d, input int n);
		i_host_port_model.xfer(p, w, d, n);
	endtask

	task automatic poke(input logic [7:0] a, input logic [7:0] d);
		xf(1'b1, 1'b0, a, 1);
		xf(1'b0, 1'b1, d, 1);
	endtask

	task automatic peek(input logic [7:0] a, output logic [7:0] q);
		xf(1'b1, 1'b0, a, 1);
		xf(1'b0, 1'b0, 8'h00, 1);
		q = i_host_port_model.rbuf[0];
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask

	task automatic final_report();
		if (errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ********
	// scenarios
	// ********
	task automatic t_reset_values();
		logic [7:0] q;
		logic [7:0] a [10] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h07, 8'h0A, 8'h0E, 8'h11, 8'h12,
			8'h7F};
		cmp("pointer", PTR_RESET, POINTER);
		cmp("run idle", 8'h02, {6'h00, CORE_RESET, CORE_CLK_EN});
		cmp("controls", 8'h00, {3'h0, PLL_BYPASS, MONO_MODE, INPUT_SELECT});
		cmp("select valid", 8'h01, {7'h00, INPUT_SELECT_VALID});
		cmp("irq pin", 8'h02, {6'h00, IRQ_OE, IRQ_OUT});
		foreach (a[i]) begin
			peek(a[i], q);
			cmp("reset value", a[i] == 8'h04 ? FIXED_CLOCK_SOURCE :
				a[i] == 8'h7F ? IDENTITY_VALUE : REG_RESET, q);
		end
	endtask

	task automatic t_write_masks();
		logic [7:0] q;
		logic [7:0] a [6] = '{8'h01, 8'h02, 8'h06, 8'h09, 8'h0C, 8'h7F};
		logic [7:0] k [6] = '{WMASK_CONTROL_ONE, WMASK_CONTROL_TWO, WMASK_SERIAL_FMT,
			WMASK_IRQ_ONE, WMASK_IRQ_TWO, IDENTITY_VALUE};
		foreach (a[i]) begin
			poke(a[i], 8'hFF);
			peek(a[i], q);
			cmp("stopped write", k[i], q);
			poke(a[i], 8'h00);
		end
	endtask

	task automatic t_auto_advance();
		xf(1'b1, 1'b0, 8'h89, 1);
		xf(1'b0, 1'b1, 8'hFF, 4);
		cmp("burst pointer", 8'h8D, POINTER);
		xf(1'b1, 1'b0, 8'h89, 1);
		xf(1'b0, 1'b0, 8'h00, 4);
		for (int i = 0; i < 4; i++)
			cmp("burst read", i == 3 ? WMASK_IRQ_TWO : WMASK_IRQ_ONE,
				i_host_port_model.rbuf[i]);
		xf(1'b1, 1'b0, 8'h0C, 1);
		xf(1'b0, 1'b0, 8'h00, 2);
		cmp("fixed pointer", 8'h0C, POINTER);
		cmp("repeat read", WMASK_IRQ_TWO, i_host_port_model.rbuf[1]);
		xf(1'b1, 1'b0, 8'hFF, 1);
		xf(1'b0, 1'b0, 8'h00, 2);
		cmp("wrap read", READ_ZERO, i_host_port_model.rbuf[1]);
		cmp("wrap pointer", 8'h81, POINTER);
		xf(1'b1, 1'b0, 8'h89, 1);
		xf(1'b0, 1'b1, 8'h00, 4);
	endtask

	task automatic t_control_outputs();
		for (int i = 0; i < 8; i++) begin
			poke(8'h02, {4'h0, i[0], i[2:0]});
			settle(1);
			cmp("mono and select", {4'h0, i[0], i[2:0]}, {4'h0, MONO_MODE, INPUT_SELECT});
			cmp("select valid", {7'h00, i != 7}, {7'h00, INPUT_SELECT_VALID});
		end
		poke(8'h02, 8'h00);
		poke(8'h04, 8'h02);
		cmp("bypass on", 8'h01, {7'h00, PLL_BYPASS});
		poke(8'h04, 8'h00);
		cmp("bypass off", 8'h00, {7'h00, PLL_BYPASS});
	endtask

	task automatic t_run_buffer();
		logic [7:0] q;
		peek(8'h25, q);
		cmp("stopped buffer", {q[7:1], q[0] | CU_BUF_READ}, READ_ZERO);
		poke(8'h04, 8'h40); // inputs steady
		settle(2);
		cmp("running", 8'h01, {6'h00, CORE_RESET, CORE_CLK_EN});
		i_host_port_model.idle = 2;
		peek(8'h25, q);
		cmp("buffer byte", 8'hC5, q);
		cmp("buffer strobe", 8'h01, {7'h00, CU_BUF_READ});
		peek(8'h17, q);
		cmp("subcode byte", 8'h33, q);
		i_host_port_model.idle = 0;
	endtask

	task automatic t_interrupt();
		logic [7:0] q;
		poke(8'h09, 8'h01);
		IRQ_SOURCES = 16'h0001;
		settle(3);
		cmp("irq raised", 8'h03, {6'h00, IRQ_OE, IRQ_OUT});
		peek(8'h07, q);
		cmp("rise status", 8'h01, q);
		peek(8'h07, q);
		cmp("status cleared", 8'h00, q);
		poke(8'h0B, 8'h01);
		IRQ_SOURCES = 16'h0000;
		settle(3);
		peek(8'h07, q);
		cmp("fall status", 8'h01, q);
		poke(8'h0A, 8'h01);
		poke(8'h0B, 8'h00);
		IRQ_SOURCES = 16'h0001;
		settle(3);
		peek(8'h07, q);
		peek(8'h07, q);
		cmp("level status", 8'h01, q);
		poke(8'h09, 8'h00);
		settle(2);
		peek(8'h07, q);
		cmp("masked status", 8'h00, q);
		cmp("masked pin", 8'h02, {6'h00, IRQ_OE, IRQ_OUT});
		poke(8'h01, 8'h02);
		settle(2);
		cmp("low idle pin", 8'h03, {6'h00, IRQ_OE, IRQ_OUT});
		poke(8'h01, 8'h04);
		settle(2);
		cmp("drain idle", 8'h00, {7'h00, IRQ_OE});
		poke(8'h09, 8'h01);
		settle(3);
		cmp("drain active", 8'h02, {6'h00, IRQ_OE, IRQ_OUT});
		poke(8'h09, 8'h00);
		poke(8'h01, 8'h00);
		IRQ_SOURCES = 16'h0000;
	endtask

	task automatic t_switch_and_stop();
		logic [7:0] q;
		poke(8'h01, 8'h80);
		PLL_LOCKED = 1'b0;
		settle(6);
		cmp("switch on", 8'h01, {7'h00, RECOVERED_CLOCK_OUTPUT_SWITCH});
		PLL_LOCKED = 1'b1;
		settle(6);
		cmp("switch off", 8'h00, {7'h00, RECOVERED_CLOCK_OUTPUT_SWITCH});
		poke(8'h04, 8'h00);
		settle(2);
		cmp("stopped", 8'h02, {6'h00, CORE_RESET, CORE_CLK_EN});
		peek(8'h2A, q);
		cmp("stopped buffer", {q[7:1], q[0] | CU_BUF_READ}, READ_ZERO);
	endtask

	// ********
	// clock, reset, run, watchdog
	// ********
	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	initial begin
		RST = 1'b1;
		IRQ_SOURCES = 16'h0000;
		PLL_LOCKED = 1'b1;
		RX_CS_DATA = 8'h96;
		RX_ERRORS = 8'h3C;
		CLOCK_RATIO_IN = 8'h81;
		errors = 0;
		tests_run = 0;
		for (int k = 0; k < SUBCODE_N; k++)
			SUBCODE_BYTES[8*k +: 8] = 8'h30 + 8'(k);
		for (int k = 0; k < CU_BUF_N; k++)
			CU_BUFFER_BYTES[8*k +: 8] = 8'hC0 + 8'(k);
		repeat (3) @(posedge CORE_CLK);
		#1;
		RST = 1'b0;
		t_reset_values();
		t_write_masks();
		t_auto_advance();
		t_control_outputs();
		t_run_buffer();
		t_interrupt();
		t_switch_and_stop();
		final_report();
	end

	initial begin
		#100000;
		errors++;
		final_report();
	end
endmodule
